/* File: verilog/plc_phy_control_status_regs.sv */
// PHY control and status register bank with CRC16 transmit append and receive check.
// Assumes an Avalon-MM master on sys_clk and PHY event inputs synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "plc_phy_defs.svh"

module plc_phy_control_status_regs #(
  parameter int PATH_RST_CYCLES = `PATH_RST_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Avalon-MM slave, byte address
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Receive path events, transmit activity and debug mode
  input wire logic preamble_detect,
  input wire logic peak1_detect,
  input wire logic peak2_detect,
  input wire logic peak2_window_miss,
  input wire logic frame_sync_detect,
  input wire logic frame_sync_fail,
  input wire logic frame_decode_done,
  input wire logic rx_robust_mode,
  input wire logic interferer_detect,
  input wire logic fec_buffer_full,
  input wire logic agc_attenuating,
  input wire logic tx_path_active,
  input wire logic debug_mode,
  // Received byte stream
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_byte_last,
  // Transmit byte stream in
  input wire logic tx_in_valid,
  input wire logic [7:0] tx_in_data,
  input wire logic tx_in_last,
  output logic tx_in_ready,
  // Transmit byte stream out
  output logic tx_out_valid,
  output logic [7:0] tx_out_data,
  output logic tx_out_last,
  input wire logic tx_out_ready,
  // Path resets and clock gates
  output logic rx_path_reset,
  output logic tx_path_reset,
  output logic phy_clk_run,
  output logic tx_clk_run,
  // Configuration mode
  output logic mem_force_enable,
  output logic phy_operation_hold,
  output logic [15:0] phy_memory_pointer,
  output logic [15:0] phy_memory_data,
  output logic mem_write_pulse,
  output logic [15:0] tx_preamble_control,
  // ACK and filter controls
  output logic expect_acknowledge,
  output logic ack_symbol_receive_enable,
  output logic preemphasis_enable,
  // AGC controls
  output logic agc_enable,
  output logic gain_control_freeze,
  output logic agc_force_attenuate,
  output logic [3:0] gain_shift_field,
  output logic [3:0] window_shift_field,
  output logic energy_free_run_mode,
  output logic [15:0] agc_forget_factor,
  output logic [15:0] agc_target_energy,
  output logic [15:0] agc_window_length
);
  initial begin
    if (PATH_RST_CYCLES < 1 || PATH_RST_CYCLES > 255) $error("PATH_RST_CYCLES out of range");
  end

  // ==========================================================
  // Bus handshake: one wait cycle, answer on the second edge
  // ==========================================================
  logic done_ff;
  wire logic req = avs_read | avs_write;
  wire logic [5:0] idx = avs_address[7:2];
  wire logic wr_fire = avs_write & done_ff;
  assign avs_waitrequest = req & ~done_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) done_ff <= 1'b0;
    else done_ff <= req & ~done_ff;
  end

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd[15:0] & m);
  endfunction

  function automatic logic hit(input logic [5:0] a, input logic [5:0] b, input logic f);
    return f && (a == b);
  endfunction

  // ==========================================================
  // Control registers
  // ==========================================================
  logic [15:0] ctrl_main_ff;
  logic [4:0] ctrl_second_ff;
  logic [15:0] mem_ptr_ff, mem_data_ff, preamble_ff;
  logic [15:0] agc_forget_ff, agc_target_ff, agc_window_ff;
  logic [9:0] agc_shift_ff;
  logic mem_wr_ff;
  logic [1:0] path_rst_done;

  wire logic cfg_mode = ctrl_main_ff[`CM_CFG];
  wire logic wr_main = hit(idx, `IDX_CTRL_MAIN, wr_fire);
  wire logic wr_second = hit(idx, `IDX_CTRL_SECOND, wr_fire);
  wire logic wr_ptr = hit(idx, `IDX_MEM_PTR, wr_fire) & cfg_mode;
  wire logic wr_data = hit(idx, `IDX_MEM_DATA, wr_fire) & cfg_mode;
  wire logic wr_pre = hit(idx, `IDX_TX_PREAMBLE, wr_fire) & cfg_mode;
  wire logic [15:0] main_wd = merge(ctrl_main_ff, avs_writedata, avs_byteenable);
  wire logic [15:0] main_keep = 16'hF304;
  wire logic [15:0] second_wd = merge({11'h000, ctrl_second_ff}, avs_writedata, avs_byteenable);
  wire logic [15:0] shift_wd = merge({6'h00, agc_shift_ff}, avs_writedata, avs_byteenable);
  wire logic dbg_wr_ok = ~ctrl_main_ff[`CM_PHY_EN];

  // Reset bits self-clear; a write of one in the done cycle restarts
  logic [15:0] nxt_ctrl_main;
  always_comb begin
    nxt_ctrl_main = wr_main ? (main_wd & main_keep) : ctrl_main_ff;
    if (path_rst_done[0] && !(wr_main && main_wd[`CM_RX_RST])) nxt_ctrl_main[`CM_RX_RST] = 1'b0;
    if (path_rst_done[1] && !(wr_main && main_wd[`CM_TX_RST])) nxt_ctrl_main[`CM_TX_RST] = 1'b0;
  end

  // Only software clears expect-ack
  wire logic [4:0] nxt_ctrl_second = {
    dbg_wr_ok ? second_wd[`CS_DBG_HALT] : ctrl_second_ff[`CS_DBG_HALT],
    second_wd[`CS_PREEMPH], 1'b0, second_wd[`CS_ACK_RX], second_wd[`CS_EXP_ACK]};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_main_ff <= 16'h0000;
      ctrl_second_ff <= 5'h00;
    end else begin
      ctrl_main_ff <= nxt_ctrl_main;
      if (wr_second) ctrl_second_ff <= nxt_ctrl_second;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mem_ptr_ff <= 16'h0000;
      mem_data_ff <= 16'h0000;
      preamble_ff <= `RST_TX_PREAMBLE;
      mem_wr_ff <= 1'b0;
    end else begin
      if (wr_ptr) mem_ptr_ff <= merge(mem_ptr_ff, avs_writedata, avs_byteenable) & `MEM_PTR_MASK;
      if (wr_data) mem_data_ff <= merge(mem_data_ff, avs_writedata, avs_byteenable);
      if (wr_pre) preamble_ff <= merge(preamble_ff, avs_writedata, avs_byteenable);
      mem_wr_ff <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      agc_forget_ff <= `RST_AGC_FORGET;
      agc_target_ff <= `RST_AGC_TARGET;
      agc_window_ff <= `RST_AGC_WINDOW;
      agc_shift_ff <= `RST_AGC_SHIFT;
    end else begin
      if (hit(idx, `IDX_AGC_FORGET, wr_fire)) agc_forget_ff <= merge(agc_forget_ff, avs_writedata, avs_byteenable);
      if (hit(idx, `IDX_AGC_TARGET, wr_fire)) agc_target_ff <= merge(agc_target_ff, avs_writedata, avs_byteenable);
      if (hit(idx, `IDX_AGC_WINDOW, wr_fire)) agc_window_ff <= merge(agc_window_ff, avs_writedata, avs_byteenable);
      if (hit(idx, `IDX_AGC_SHIFT, wr_fire)) agc_shift_ff <= shift_wd[9:0];
    end
  end

  // ==========================================================
  // Path reset pulse counters
  // ==========================================================
  wire logic [1:0] path_rst_bit = {ctrl_main_ff[`CM_TX_RST], ctrl_main_ff[`CM_RX_RST]};

  for (genvar g = 0; g < 2; g++) begin : g_path_rst
    logic [7:0] cnt_ff;
    wire logic [7:0] last_cnt = 8'(PATH_RST_CYCLES - 1);
    assign path_rst_done[g] = path_rst_bit[g] && (cnt_ff == last_cnt);
    always_ff @(posedge sys_clk) begin
      if (rst || !path_rst_bit[g] || path_rst_done[g]) cnt_ff <= 8'h00;
      else cnt_ff <= cnt_ff + 8'h01;
    end
  end

  wire logic rx_rst_int = rst | path_rst_bit[0];
  wire logic tx_rst_int = rst | path_rst_bit[1];
  assign rx_path_reset = rx_rst_int;
  assign tx_path_reset = tx_rst_int;

  // ==========================================================
  // Control outputs
  // ==========================================================
  wire logic halted = ctrl_second_ff[`CS_DBG_HALT] & debug_mode;
  assign phy_clk_run = ~halted;
  assign tx_clk_run = ctrl_main_ff[`CM_PHY_EN] & ~halted;
  assign mem_force_enable = cfg_mode;
  assign phy_operation_hold = cfg_mode;
  assign phy_memory_pointer = mem_ptr_ff;
  assign phy_memory_data = mem_data_ff;
  assign mem_write_pulse = mem_wr_ff;
  assign tx_preamble_control = preamble_ff;
  assign expect_acknowledge = ctrl_second_ff[`CS_EXP_ACK];
  assign ack_symbol_receive_enable = ctrl_second_ff[`CS_ACK_RX];
  assign preemphasis_enable = ctrl_second_ff[`CS_PREEMPH];
  assign agc_enable = ctrl_main_ff[`CM_AGC_EN];
  assign gain_control_freeze = ctrl_main_ff[`CM_FREEZE];
  assign agc_force_attenuate = ctrl_main_ff[`CM_FREEZE] & agc_shift_ff[8];
  assign gain_shift_field = agc_shift_ff[7:4];
  assign window_shift_field = agc_shift_ff[3:0];
  assign energy_free_run_mode = agc_shift_ff[9];
  assign agc_forget_factor = agc_forget_ff;
  assign agc_target_energy = agc_target_ff;
  assign agc_window_length = agc_window_ff;

  // ==========================================================
  // Transmit CRC append
  // ==========================================================
  plc_phy_pkg::tx_state_t tx_state_ff, nxt_tx_state;
  logic [15:0] tx_crc;
  logic tx_out_valid_ff, tx_out_last_ff;
  logic [7:0] tx_out_data_ff;

  wire logic out_free = ~tx_out_valid_ff | tx_out_ready;
  wire logic tx_take = tx_in_valid & tx_in_ready;
  wire logic crc_on = ctrl_main_ff[`CM_CRC_EN];
  wire logic load_hi = (tx_state_ff == plc_phy_pkg::TX_CRC_HI) & out_free;
  wire logic load_lo = (tx_state_ff == plc_phy_pkg::TX_CRC_LO) & out_free;
  assign tx_in_ready = (tx_state_ff == plc_phy_pkg::TX_DATA) & out_free & ~cfg_mode & ~tx_rst_int;

  always_comb begin
    case (tx_state_ff)
      plc_phy_pkg::TX_DATA: nxt_tx_state = (tx_take && tx_in_last && crc_on) ? plc_phy_pkg::TX_CRC_HI
                                                                              : plc_phy_pkg::TX_DATA;
      plc_phy_pkg::TX_CRC_HI: nxt_tx_state = load_hi ? plc_phy_pkg::TX_CRC_LO : plc_phy_pkg::TX_CRC_HI;
      plc_phy_pkg::TX_CRC_LO: nxt_tx_state = load_lo ? plc_phy_pkg::TX_DATA : plc_phy_pkg::TX_CRC_LO;
      default: nxt_tx_state = plc_phy_pkg::TX_DATA;
    endcase
  end

  logic tx_crc_clear_ff;
  plc_crc16 u_tx_crc (
    .sys_clk(sys_clk),
    .rst(tx_rst_int),
    .clear(tx_crc_clear_ff),
    .byte_valid(tx_take),
    .byte_data(tx_in_data),
    .crc(tx_crc)
  );

  always_ff @(posedge sys_clk) begin
    if (tx_rst_int) begin
      tx_state_ff <= plc_phy_pkg::TX_DATA;
      tx_out_valid_ff <= 1'b0;
      tx_out_data_ff <= 8'h00;
      tx_out_last_ff <= 1'b0;
      tx_crc_clear_ff <= 1'b0;
    end else begin
      tx_state_ff <= nxt_tx_state;
      tx_crc_clear_ff <= (tx_take && tx_in_last && !crc_on) || load_lo;
      if (tx_take) begin
        tx_out_valid_ff <= 1'b1;
        tx_out_data_ff <= tx_in_data;
        tx_out_last_ff <= tx_in_last & ~crc_on;
      end else if (load_hi || load_lo) begin
        tx_out_valid_ff <= 1'b1;
        tx_out_data_ff <= load_hi ? tx_crc[15:8] : tx_crc[7:0];
        tx_out_last_ff <= load_lo;
      end else if (tx_out_ready) begin
        tx_out_valid_ff <= 1'b0;
      end
    end
  end

  assign tx_out_valid = tx_out_valid_ff;
  assign tx_out_data = tx_out_data_ff;
  assign tx_out_last = tx_out_last_ff;

  // ==========================================================
  // Receive CRC check
  // ==========================================================
  logic [15:0] rx_crc;
  logic rx_end_ff, crc_good_ff;

  plc_crc16 u_rx_crc (
    .sys_clk(sys_clk),
    .rst(rx_rst_int),
    .clear(rx_end_ff),
    .byte_valid(rx_byte_valid),
    .byte_data(rx_byte),
    .crc(rx_crc)
  );

  always_ff @(posedge sys_clk) begin
    if (rx_rst_int) begin
      rx_end_ff <= 1'b0;
      crc_good_ff <= 1'b0;
    end else begin
      rx_end_ff <= rx_byte_valid & rx_byte_last;
      if (rx_end_ff) crc_good_ff <= (rx_crc == 16'h0000);
    end
  end

  // ==========================================================
  // Status flags
  // ==========================================================
  logic cs_ff, p1_ff, p2_ff, frm_ff, mode_ff, busy_ff, jam_ff, fec_ff, attenuating_flag_ff;
  wire logic cs_end = frame_decode_done | frame_sync_fail | peak2_window_miss;
  wire logic tx_active = tx_path_active | tx_out_valid_ff | (tx_state_ff != plc_phy_pkg::TX_DATA);
  wire logic attenuating_flag_src = ctrl_main_ff[`CM_FREEZE] ? agc_shift_ff[8] : agc_attenuating;

  always_ff @(posedge sys_clk) begin
    if (rx_rst_int) begin
      cs_ff <= 1'b0;
      p1_ff <= 1'b0;
      p2_ff <= 1'b0;
      frm_ff <= 1'b0;
      mode_ff <= 1'b0;
    end else begin
      cs_ff <= preamble_detect | (cs_ff & ~cs_end);
      p1_ff <= peak1_detect | (p1_ff & ~cs_end);
      p2_ff <= peak2_detect | (p2_ff & ~cs_end);
      frm_ff <= frame_sync_detect | (frm_ff & ~(frame_decode_done | frame_sync_fail));
      if (frame_sync_detect) mode_ff <= rx_robust_mode;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy_ff <= 1'b0;
      jam_ff <= 1'b0;
      fec_ff <= 1'b0;
      attenuating_flag_ff <= 1'b0;
    end else begin
      busy_ff <= tx_active;
      jam_ff <= interferer_detect;
      fec_ff <= fec_buffer_full;
      attenuating_flag_ff <= ctrl_main_ff[`CM_AGC_EN] & attenuating_flag_src;
    end
  end

  // ==========================================================
  // Read mux, registered on the waiting edge
  // ==========================================================
  wire logic [15:0] status_rd = {6'h00, fec_ff, attenuating_flag_ff, crc_good_ff, frm_ff, jam_ff, busy_ff,
                                 mode_ff, p2_ff, p1_ff, cs_ff};
  wire logic [15:0] rd_word =
    (idx == `IDX_MEM_PTR) ? mem_ptr_ff :
    (idx == `IDX_MEM_DATA) ? mem_data_ff :
    (idx == `IDX_CTRL_MAIN) ? ctrl_main_ff :
    (idx == `IDX_STATUS) ? status_rd :
    (idx == `IDX_CTRL_SECOND) ? {11'h000, ctrl_second_ff} :
    (idx == `IDX_AGC_FORGET) ? agc_forget_ff :
    (idx == `IDX_AGC_TARGET) ? agc_target_ff :
    (idx == `IDX_AGC_WINDOW) ? agc_window_ff :
    (idx == `IDX_AGC_SHIFT) ? {6'h00, agc_shift_ff} :
    (idx == `IDX_TX_PREAMBLE) ? preamble_ff : 16'h0000;

  always_ff @(posedge sys_clk) begin
    if (rst) avs_readdata <= 32'h0000_0000;
    else if (avs_read && !done_ff) avs_readdata <= {16'h0000, rd_word};
  end
endmodule

`default_nettype wire

/* File: verilog/plc_phy_defs.svh */
// Offsets, field positions, reset values and counts of the PHY control bank.
// Assumes inclusion by bare name from the package and the bank module.
//
// How it works
// - Receive-reset bit resets receive path, OR'd with global reset, then self-clears.
// - Transmit-reset bit resets transmit path, OR'd with global reset, then self-clears.
// - Checksum enable set: transmitter appends CRC16 to each frame; clear: data only.
// - Receiver always checks CRC16 over data plus last two bytes.
// - Configuration mode forces memory enables active and holds normal PHY operation.
// - Pointer, memory data and preamble control writes only land in configuration mode.
// - Expect-acknowledge enables ACK detection; only software clears it.
// - ACK-receive enable turns on ACK symbol detection and auto-response.
// - Pre-emphasis enable filters transmitted tones; resets to off.
// - Debug-halt stops PHY clocks in debug mode; writable only while PHY disabled.
// - Status register ignores writes; unused upper bits read zero.
// - Carrier sense rises on preamble; clears on decode, sync failure or peak2 timeout.
// - First-peak and second-peak flags rise on their preamble detections.
// - Received-frame-mode reads one for robust frames, zero for normal.
// - Transmitter-busy is high during any transmit activity, low when idle.
// - Frame-received asserts on frame sync and holds while reception runs.
// - Checksum-good is high when received CRC16 is valid, else low.
// - Attenuating flag follows AGC direction; reads zero when AGC disabled.
// - FEC-pending flag is high while the receive FEC buffer holds a frame.
// - With freeze set, override bit forces attenuate or amplify; else ignored.
// - Energy free-run bit selects free-running RMS or start-of-data energy calculation.
// - PHY clock enable gates only the transmit path clock; PHY clock runs unless debug-halted.
// - Freeze stops automatic gain; fixed gain set by gain-shift field.
`ifndef PLC_PHY_DEFS_SVH
`define PLC_PHY_DEFS_SVH

// Register indices; byte address is four times the index
`define IDX_MEM_PTR 6'h00
`define IDX_MEM_DATA 6'h01
`define IDX_CTRL_MAIN 6'h03
`define IDX_STATUS 6'h04
`define IDX_CTRL_SECOND 6'h05
`define IDX_AGC_FORGET 6'h07
`define IDX_AGC_TARGET 6'h08
`define IDX_AGC_WINDOW 6'h09
`define IDX_AGC_SHIFT 6'h0A
`define IDX_TX_PREAMBLE 6'h14

// Main control field positions
`define CM_PHY_EN 2
`define CM_AGC_EN 8
`define CM_FREEZE 9
`define CM_RX_RST 12
`define CM_TX_RST 13
`define CM_CRC_EN 14
`define CM_CFG 15

// Second control field positions
`define CS_EXP_ACK 0
`define CS_ACK_RX 1
`define CS_PREEMPH 3
`define CS_DBG_HALT 4

// Reset values and memory pointer mask
`define RST_AGC_FORGET 16'h007C
`define RST_AGC_TARGET 16'h00F0
`define RST_AGC_WINDOW 16'h00FF
`define RST_AGC_SHIFT 10'h008
`define RST_TX_PREAMBLE 16'h0044
`define MEM_PTR_MASK 16'h1FFF

// CRC16
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'h1021

// Path reset pulse length in clock cycles
`define PATH_RST_CYCLES 8

`endif

/* File: verilog/plc_phy_pkg.sv */
// Types used by the PHY control bank.
// Assumes the defs header is on the include path.
`include "plc_phy_defs.svh"

package plc_phy_pkg;
  typedef logic [15:0] reg_word_t;
  // Gray coded along data -> high byte -> low byte
  typedef enum logic [1:0] {
    TX_DATA = 2'b00,
    TX_CRC_HI = 2'b01,
    TX_CRC_LO = 2'b11
  } tx_state_t;
endpackage

/* File: verilog/plc_crc16.sv */
// CRC16 engine, MSB first, one byte per cycle.
// Assumes the caller clears it between frames.
`timescale 1ns/1ps
`default_nettype none
`include "plc_phy_defs.svh"

module plc_crc16 (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Byte stream
  input wire logic clear,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  // Running value
  output logic [15:0] crc
);
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r = {r[14:0], 1'b0} ^ (fb ? `CRC_POLY : 16'h0000);
    end
    return r;
  endfunction

  wire logic [15:0] base = clear ? `CRC_INIT : crc;
  wire logic [15:0] nxt_crc = byte_valid ? crc_step(base, byte_data) : base;

  always_ff @(posedge sys_clk) begin
    if (rst) crc <= `CRC_INIT;
    else crc <= nxt_crc;
  end
endmodule

`default_nettype wire

/* File: test/plc_phy_regs_properties.sv */
// Checks on the PHY control bank ports.
// Assumes a bind onto the bank; rst is sync.
`timescale 1ns/1ps
`default_nettype none
module plc_phy_regs_properties #(
  parameter int PATH_RST_CYCLES = 2
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  // Controls and gates
  input wire logic debug_mode,
  input wire logic tx_in_ready,
  input wire logic rx_path_reset,
  input wire logic tx_path_reset,
  input wire logic phy_clk_run,
  input wire logic tx_clk_run,
  input wire logic mem_force_enable,
  input wire logic phy_operation_hold,
  input wire logic gain_control_freeze,
  input wire logic agc_force_attenuate
);
  // ====
  // Transmit reset pulse length
  logic [7:0] tx_n_ff;
  always_ff @(posedge sys_clk) begin
    if (rst || !tx_path_reset) tx_n_ff <= 8'h00;
    else tx_n_ff <= tx_n_ff + 8'h01;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ====
  // Properties
  chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("long wait");
  chk_upper_zero: assert property (avs_readdata[31:16] == 16'h0000)
    else $error("upper bits");
  chk_cfg_pair: assert property (mem_force_enable == phy_operation_hold)
    else $error("cfg pair");
  chk_cfg_stall: assert property (mem_force_enable |-> !tx_in_ready)
    else $error("cfg ready");
  chk_force_freeze: assert property (agc_force_attenuate |-> gain_control_freeze)
    else $error("force");
  chk_halt_gate: assert property (!phy_clk_run |-> debug_mode && !tx_clk_run)
    else $error("clock gate");
  chk_grst_path: assert property (disable iff (1'b0) rst |-> rx_path_reset && tx_path_reset)
    else $error("path reset");
  chk_tx_len: assert property (tx_path_reset |-> tx_n_ff < PATH_RST_CYCLES)
    else $error("tx reset long");
  chk_tx_end: assert property ($fell(tx_path_reset) && !$past(rst) |-> $past(tx_n_ff) == PATH_RST_CYCLES - 1)
    else $error("tx reset short");
endmodule
`default_nettype wire

/* File: test/plc_tx_sink.sv */
// Transmit byte sink.
// Assumes the bench drives stall; keeps three bytes.
`timescale 1ns/1ps
`default_nettype none
module plc_tx_sink (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Stream from the bank
  input wire logic tx_out_valid,
  input wire logic [7:0] tx_out_data,
  input wire logic tx_out_last,
  output logic tx_out_ready,
  // Observation
  input wire logic stall,
  output logic [23:0] seen,
  output logic [7:0] n_bytes,
  output logic saw_last
);
  assign tx_out_ready = !stall;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seen <= 24'h000000;
      n_bytes <= 8'h00;
      saw_last <= 1'b0;
    end else if (tx_out_valid && tx_out_ready) begin
      seen <= {seen[15:0], tx_out_data};
      n_bytes <= n_bytes + 8'h01;
      saw_last <= tx_out_last;
    end
  end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// Bench for the PHY control bank.
// Assumes bank, sink and checker compile with it.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, robust, jam, fec, atten, txact, dbg;
  logic rxv, rxl, txv, txl, txrdy, ov, ol, ordy, stall, saw_last, rxr, pclk, mfe, ea, ar, pe, afa;
  logic [7:0] avs_address, rxb, txd, od, n_bytes;
  logic [31:0] avs_writedata, avs_readdata;
  logic [23:0] seen;
  logic [6:0] ev;
  int error_cnt, n_checks, rx_hi;
  plc_phy_control_status_regs #(.PATH_RST_CYCLES(2)) u_plc_phy_control_status_regs (
    .sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
    .avs_waitrequest, .preamble_detect(ev[6]), .peak1_detect(ev[5]), .peak2_detect(ev[4]),
    .peak2_window_miss(ev[3]), .frame_sync_detect(ev[2]), .frame_sync_fail(ev[1]), .frame_decode_done(ev[0]),
    .rx_robust_mode(robust), .interferer_detect(jam), .fec_buffer_full(fec), .agc_attenuating(atten),
    .tx_path_active(txact), .debug_mode(dbg), .rx_byte_valid(rxv), .rx_byte(rxb), .rx_byte_last(rxl),
    .tx_in_valid(txv), .tx_in_data(txd), .tx_in_last(txl), .tx_in_ready(txrdy), .tx_out_valid(ov),
    .tx_out_data(od), .tx_out_last(ol), .tx_out_ready(ordy), .rx_path_reset(rxr), .tx_path_reset(),
    .phy_clk_run(pclk), .tx_clk_run(), .mem_force_enable(mfe), .phy_operation_hold(), .phy_memory_pointer(),
    .phy_memory_data(), .mem_write_pulse(), .tx_preamble_control(), .expect_acknowledge(ea),
    .ack_symbol_receive_enable(ar), .preemphasis_enable(pe), .agc_enable(), .gain_control_freeze(),
    .agc_force_attenuate(afa), .gain_shift_field(), .window_shift_field(), .energy_free_run_mode(),
    .agc_forget_factor(), .agc_target_energy(), .agc_window_length());
  plc_tx_sink u_plc_tx_sink (.sys_clk, .rst, .tx_out_valid(ov), .tx_out_data(od), .tx_out_last(ol),
    .tx_out_ready(ordy), .stall, .seen, .n_bytes, .saw_last);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) if (rxr === 1'b1) rx_hi++;
  // ====
  // Common tasks
  function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) c = {c[14:0], 1'b0} ^ (c[15] ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  task automatic stop_test();
    if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic ck(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int sel, input logic [7:0] tgt);
    int k;
    for (k = 0; k < 50; k++) begin
      @(negedge sys_clk);
      if (sel == 0 ? avs_waitrequest === 1'b0 : sel == 1 ? txrdy : n_bytes === tgt) break;
    end
    if (k == 50) begin
      error_cnt++;
      stop_test();
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] i, input logic [15:0] d);
    @(posedge sys_clk);
    avs_address <= {i, 2'b00};
    {avs_write, avs_read} <= {w, !w};
    avs_writedata <= {16'h0000, d};
    wt(0, 8'h00);
    @(posedge sys_clk);
    {avs_write, avs_read} <= 2'b00;
    if (!w) ck(avs_readdata[15:0], d);
    @(negedge sys_clk);
  endtask
  task automatic wr(input logic [5:0] i, input logic [15:0] d);
    bus(1'b1, i, d);
  endtask
  task automatic rc(input logic [5:0] i, input logic [15:0] e);
    bus(1'b0, i, e);
  endtask
  task automatic pulse(input logic [6:0] m);
    @(posedge sys_clk) ev <= m;
    @(posedge sys_clk) ev <= 7'h00;
  endtask
  // ====
  // Scenarios
  task automatic t_defaults();
    rc(6'h03, 16'h0000);
    rc(6'h04, 16'h0000);
    rc(6'h05, 16'h0000);
    rc(6'h07, 16'h007C);
    rc(6'h08, 16'h00F0);
    rc(6'h09, 16'h00FF);
    rc(6'h0A, 16'h0008);
    wr(6'h02, 16'h1234);
    rc(6'h02, 16'h0000);
  endtask
  task automatic t_cfg();
    wr(6'h00, 16'hFFFF);
    rc(6'h00, 16'h0000);
    wr(6'h03, 16'h8000);
    ck(16'(mfe), 16'h0001);
    ck(16'(txrdy), 16'h0000);
    wr(6'h00, 16'hFFFF);
    rc(6'h00, 16'h1FFF);
    wr(6'h14, 16'h0123);
    rc(6'h14, 16'h0123);
    wr(6'h03, 16'h0000);
    wr(6'h14, 16'h0456);
    rc(6'h14, 16'h0123);
  endtask
  task automatic t_path();
    rx_hi = 0;
    wr(6'h03, 16'h1000);
    repeat (8) @(negedge sys_clk);
    ck(rx_hi[15:0], 16'h0002);
    rc(6'h03, 16'h0000);
    wr(6'h03, 16'h2000);
    repeat (8) @(negedge sys_clk);
    rc(6'h03, 16'h0000);
  endtask
  task automatic t_halt();
    wr(6'h03, 16'h0004);
    wr(6'h05, 16'h0010);
    rc(6'h05, 16'h0000);
    wr(6'h03, 16'h0000);
    wr(6'h05, 16'h00FF);
    rc(6'h05, 16'h001B);
    ck({13'h0000, ea, ar, pe}, 16'h0007);
    @(posedge sys_clk) dbg <= 1'b1;
    @(negedge sys_clk);
    ck(16'(pclk), 16'h0000);
    @(posedge sys_clk) dbg <= 1'b0;
    wr(6'h05, 16'h0000);
  endtask
  task automatic t_status();
    @(posedge sys_clk) robust <= 1'b1;
    pulse(7'h74);
    rc(6'h04, 16'h004F);
    wr(6'h04, 16'h0000);
    rc(6'h04, 16'h004F);
    pulse(7'h08);
    rc(6'h04, 16'h0048);
    pulse(7'h01);
    rc(6'h04, 16'h0008);
    @(posedge sys_clk) {txact, fec, atten, jam} <= 4'hF;
    rc(6'h04, 16'h0238);
    wr(6'h03, 16'h0100);
    rc(6'h04, 16'h0338);
    wr(6'h03, 16'h0300);
    rc(6'h04, 16'h0238);
    wr(6'h0A, 16'h0108);
    rc(6'h04, 16'h0338);
    ck(16'(afa), 16'h0001);
    wr(6'h0A, 16'h0008);
    wr(6'h03, 16'h0000);
    @(posedge sys_clk) {txact, fec, atten, jam} <= 4'h0;
  endtask
  task automatic t_tx(input logic en, input logic [7:0] b);
    logic [15:0] c;
    logic [7:0] n0;
    c = crc(16'hFFFF, b);
    n0 = n_bytes;
    wr(6'h03, {1'b0, en, 14'h0000});
    @(posedge sys_clk) {stall, txv, txl, txd} <= {3'b111, b};
    wt(1, 8'h00);
    @(posedge sys_clk) txv <= 1'b0;
    repeat (3) @(posedge sys_clk);
    stall <= 1'b0;
    wt(2, n0 + (en ? 8'h03 : 8'h01));
    ck(en ? seen[15:0] : {8'h00, seen[7:0]}, en ? c : {8'h00, b});
    ck({7'h00, saw_last, seen[23:16]}, {7'h00, 1'b1, en ? b : seen[23:16]});
  endtask
  task automatic t_rx(input logic bad);
    logic [15:0] c;
    logic [7:0] f [4];
    c = crc(crc(16'hFFFF, 8'hA5), 8'h3C);
    f = '{8'hA5, 8'h3C, c[15:8], c[7:0] ^ {7'h00, bad}};
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk) {rxv, rxl, rxb} <= {1'b1, i == 3, f[i]};
    end
    @(posedge sys_clk) rxv <= 1'b0;
    rc(6'h04, {8'h00, !bad, 7'h08});
  endtask
  // ====
  // Main sequence
  initial begin
    rst = 1'b1;
    {avs_read, avs_write, avs_address, avs_writedata, ev, robust, jam, fec, atten, txact, dbg} = '0;
    {rxv, rxl, rxb, txv, txl, txd, stall} = '0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    t_defaults();
    t_cfg();
    t_path();
    t_halt();
    t_status();
    t_tx(1'b1, 8'h5A);
    t_tx(1'b0, 8'hC3);
    t_rx(1'b0);
    t_rx(1'b1);
    stop_test();
  end
endmodule
bind plc_phy_control_status_regs plc_phy_regs_properties #(.PATH_RST_CYCLES(PATH_RST_CYCLES)) u_props (
  .sys_clk, .rst, .avs_read, .avs_write, .avs_waitrequest, .avs_readdata, .debug_mode, .tx_in_ready,
  .rx_path_reset, .tx_path_reset, .phy_clk_run, .tx_clk_run, .mem_force_enable, .phy_operation_hold,
  .gain_control_freeze, .agc_force_attenuate);
`default_nettype wire
